// >>> design/rx_moderation.sv
// receive descriptor thresholds and interrupt moderation timers with a wishbone slave
`timescale 1ns/1ps
module rx_moderation #(
	parameter int TICK_DIV = rx_moderation_pkg::TICK_CYCLES
) (
	input wire logic clk_i, // core clock 100 MHz
	input wire logic rst_i, // synchronous reset, high
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // write enable
	input wire logic [15:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	input wire logic [6:0] onchip_valid_i, // unprocessed descriptors held on chip
	input wire logic [15:0] host_valid_i, // valid descriptors in host ring
	input wire logic [6:0] wb_ready_i, // processed descriptors awaiting write-back
	input wire logic pkt_stored_i, // pulse: packet stored in system memory
	input wire logic [13:0] pkt_len_i, // length incl headers, crc, vlan tag
	input wire logic vlan_stripped_i, // the packet vlan tag was stripped
	input wire logic ack_rx_i, // pulse: ack frame received
	input wire logic small_en_i, // small-packet interrupt enabled in mask
	input wire logic ack_en_i, // ack interrupt enabled in mask
	output logic prefetch_req_o, // level: fetch descriptors now
	output logic writeback_req_o, // level: write back now
	output logic flush_o, // pulse: flush pending write-backs
	output logic rx_timer_irq_o, // pulse: receive timer interrupt
	output logic small_irq_o, // pulse: small packet interrupt
	output logic ack_irq_o // pulse: ack interrupt
);
	// the tick counter is 16 bits wide and needs at least one cycle per tick
	if (TICK_DIV < 1 || TICK_DIV > 65535) begin : g_bad_tick_div
		$error("TICK_DIV out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [31:0] q0_ctrl;
		logic [31:0] q1_ctrl;
		logic [15:0] abs_delay;
		logic [15:0] pkt_delay;
		logic [11:0] small_size;
		logic [15:0] ack_delay;
		logic [7:0] line_words;
		logic [15:0] tick_cnt;
		logic tick;
		logic [31:0] rdata;
		logic ack;
		logic prefetch;
		logic writeback;
		logic flush;
		logic timer_irq;
		logic small_irq;
		logic ack_irq;
		logic fpd;
		logic abs_pending;
		logic pkt_pending;
	} state_s;
	state_s s_r;
	state_s s_nxt;

	delay_timer_if abs_if ();
	delay_timer_if pkt_if ();
	delay_timer_if ack_if ();

	delay_timer u_abs (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tmr(abs_if.timer)
	);
	delay_timer u_pkt (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tmr(pkt_if.timer)
	);
	delay_timer u_ack (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tmr(ack_if.timer)
	);

	////////////////////////////////////////////////////////////////////////////////
	// threshold conversion

	// threshold field to descriptor count; a line of words*4 bytes holds words/4 descriptors
	function automatic logic [11:0] to_desc(input logic [5:0] field, input logic unit_sel, input logic [7:0] words);
		logic [11:0] per_line;
		per_line = {4'h0, words} >> 2;
		if (unit_sel) begin
			to_desc = {6'h00, field};
		end else begin
			to_desc = 12'(field * per_line);
		end
	endfunction

	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wr, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = wr[i*8 +: 8];
			end
		end
		lane_merge = res;
	endfunction

	logic [11:0] pth_d;
	logic [11:0] hth_d;
	logic [11:0] wth_d;
	logic [13:0] cmp_len;
	logic bus_req;
	logic bus_wr;

	always_comb begin
		pth_d = to_desc(s_r.q0_ctrl[rx_moderation_pkg::PTH_LSB +: 6], s_r.q0_ctrl[rx_moderation_pkg::UNIT_SEL_BIT],
			s_r.line_words);
		hth_d = to_desc(s_r.q0_ctrl[rx_moderation_pkg::HTH_LSB +: 6], s_r.q0_ctrl[rx_moderation_pkg::UNIT_SEL_BIT],
			s_r.line_words);
		wth_d = to_desc(s_r.q0_ctrl[rx_moderation_pkg::WTH_LSB +: 6], s_r.q0_ctrl[rx_moderation_pkg::UNIT_SEL_BIT],
			s_r.line_words);
		cmp_len = vlan_stripped_i ? pkt_len_i - 14'(rx_moderation_pkg::VLAN_TAG_BYTES) : pkt_len_i;
		bus_req = wb_cyc_i && wb_stb_i && !s_r.ack;
		bus_wr = bus_req && wb_we_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	// timer controls

	always_comb begin
		abs_if.load_value = s_r.abs_delay;
		pkt_if.load_value = s_r.pkt_delay;
		ack_if.load_value = s_r.ack_delay;
		abs_if.tick = s_r.tick;
		pkt_if.tick = s_r.tick;
		ack_if.tick = s_r.tick;
		// a packet starts the absolute timer only if idle and enabled
		abs_if.load = pkt_stored_i && s_r.abs_delay != 16'h0000 && !abs_if.running && !pkt_if.expired;
		pkt_if.load = pkt_stored_i;
		abs_if.halt_load = pkt_if.expired || s_r.fpd;
		// a packet in the expiry cycle restarts the packet timer instead of being lost
		pkt_if.halt_load = abs_if.expired && !pkt_stored_i;
		ack_if.load = ack_rx_i && ack_en_i && !ack_if.running;
		ack_if.halt_load = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_nxt = s_r;
		s_nxt.ack = bus_req;
		s_nxt.fpd = 1'b0;
		s_nxt.flush = 1'b0;
		s_nxt.timer_irq = 1'b0;
		s_nxt.small_irq = 1'b0;
		s_nxt.ack_irq = 1'b0;

		// common tick divider
		if (s_r.tick_cnt == 16'(TICK_DIV - 1)) begin
			s_nxt.tick_cnt = 16'h0000;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.tick_cnt = s_r.tick_cnt + 16'h0001;
			s_nxt.tick = 1'b0;
		end

		if (bus_wr) begin
			case (wb_adr_i)
				rx_moderation_pkg::OFS_Q0_CTRL: begin
					s_nxt.q0_ctrl = lane_merge(s_r.q0_ctrl, wb_dat_i, wb_sel_i) & rx_moderation_pkg::CTRL_MASK;
					s_nxt.q1_ctrl = lane_merge(s_r.q0_ctrl, wb_dat_i, wb_sel_i) & rx_moderation_pkg::CTRL_MASK;
				end
				rx_moderation_pkg::OFS_Q1_CTRL: begin
					s_nxt.q1_ctrl = lane_merge(s_r.q1_ctrl, wb_dat_i, wb_sel_i) & rx_moderation_pkg::CTRL_MASK;
				end
				rx_moderation_pkg::OFS_ABS_DELAY: begin
					s_nxt.abs_delay = 16'(lane_merge({16'h0000, s_r.abs_delay}, wb_dat_i, wb_sel_i));
				end
				rx_moderation_pkg::OFS_PKT_DELAY: begin
					s_nxt.pkt_delay = 16'(lane_merge({16'h0000, s_r.pkt_delay}, wb_dat_i, wb_sel_i));
					s_nxt.fpd = wb_sel_i[3] && wb_dat_i[rx_moderation_pkg::FLUSH_BIT];
				end
				rx_moderation_pkg::OFS_SMALL_SIZE: begin
					s_nxt.small_size = 12'(lane_merge({20'h00000, s_r.small_size}, wb_dat_i, wb_sel_i));
				end
				rx_moderation_pkg::OFS_ACK_DELAY: begin
					s_nxt.ack_delay = 16'(lane_merge({16'h0000, s_r.ack_delay}, wb_dat_i, wb_sel_i));
				end
				rx_moderation_pkg::OFS_CFG: begin
					s_nxt.line_words = 8'(lane_merge({24'h000000, s_r.line_words}, wb_dat_i, wb_sel_i));
				end
				default: begin
				end
			endcase
		end

		if (bus_req && !wb_we_i) begin
			case (wb_adr_i)
				rx_moderation_pkg::OFS_Q0_CTRL: s_nxt.rdata = s_r.q0_ctrl;
				rx_moderation_pkg::OFS_Q1_CTRL: s_nxt.rdata = s_r.q1_ctrl;
				rx_moderation_pkg::OFS_ABS_DELAY: s_nxt.rdata = {16'h0000, s_r.abs_delay};
				rx_moderation_pkg::OFS_PKT_DELAY: s_nxt.rdata = {16'h0000, s_r.pkt_delay};
				rx_moderation_pkg::OFS_SMALL_SIZE: s_nxt.rdata = {20'h00000, s_r.small_size};
				rx_moderation_pkg::OFS_ACK_DELAY: s_nxt.rdata = {16'h0000, s_r.ack_delay};
				rx_moderation_pkg::OFS_CFG: s_nxt.rdata = {24'h000000, s_r.line_words};
				rx_moderation_pkg::OFS_STATUS: s_nxt.rdata = {26'h0000000, s_r.pkt_pending, s_r.abs_pending,
					ack_if.running, pkt_if.running, abs_if.running, s_r.prefetch};
				default: s_nxt.rdata = 32'h00000000;
			endcase
		end

		// descriptor movement requests, in descriptor units
		s_nxt.prefetch = ({5'h00, onchip_valid_i} < pth_d) && (host_valid_i[11:0] >= hth_d
			|| host_valid_i[15:12] != 4'h0);
		s_nxt.writeback = ({5'h00, wb_ready_i} >= wth_d) && wb_ready_i != 7'h00;

		// pending flags: for the packet flag, hardware set wins over cancel
		if (pkt_stored_i) begin
			s_nxt.pkt_pending = 1'b1;
		end else if (abs_if.expired || pkt_if.expired) begin
			s_nxt.pkt_pending = 1'b0;
		end
		// the absolute timer itself is halted by a cancel, so the cancel must win here
		if (pkt_if.expired || s_r.fpd) begin
			s_nxt.abs_pending = 1'b0;
		end else if (abs_if.load) begin
			s_nxt.abs_pending = 1'b1;
		end else if (abs_if.expired) begin
			s_nxt.abs_pending = 1'b0;
		end

		// an absolute or packet timer expiry or an explicit flush writes back and interrupts
		if (abs_if.expired || pkt_if.expired || s_r.fpd) begin
			s_nxt.flush = 1'b1;
			s_nxt.timer_irq = 1'b1;
			s_nxt.writeback = wb_ready_i != 7'h00;
		end

		if (pkt_stored_i && small_en_i && cmp_len <= {2'b00, s_r.small_size}) begin
			s_nxt.small_irq = 1'b1;
		end
		s_nxt.ack_irq = ack_if.expired;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
			s_r.q0_ctrl <= rx_moderation_pkg::CTRL_RESET;
			s_r.q1_ctrl <= rx_moderation_pkg::CTRL_RESET;
			s_r.line_words <= rx_moderation_pkg::LINE_WORDS_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign wb_dat_o = s_r.rdata;
	assign wb_ack_o = s_r.ack;
	assign prefetch_req_o = s_r.prefetch;
	assign writeback_req_o = s_r.writeback;
	assign flush_o = s_r.flush;
	assign rx_timer_irq_o = s_r.timer_irq;
	assign small_irq_o = s_r.small_irq;
	assign ack_irq_o = s_r.ack_irq;
endmodule

// >>> design/rx_moderation_pkg.sv
// constants and register map shared by the receive moderation block
// Overview of operation
// - granularity bit 24: 0 means thresholds in cache lines, 1 means descriptors
// - every receive descriptor is a 16-byte unit
// - consider a prefetch when on-chip valid descriptors fall below prefetch threshold
// - prefetch only if host holds at least host-available-threshold descriptors
// - write back only when write-back threshold descriptors are ready, unless flushed
// - queue 0 control write also copies into queue 1; queue 1 write alone
// - absolute delay is 16 bits of 1.024 us ticks; zero disables it
// - absolute timer starts when a packet is stored to system memory
// - absolute expiry flushes pending write-backs and raises receive timer interrupt
// - packet timer interrupt cancels absolute one; absolute reloaded and halted
// - small-packet interrupt for packets whose length is at most the size field
// - compared length includes headers and crc, excludes a stripped vlan tag
// - ack with timer idle loads ack timer; interrupt only on its expiry
// - an ack while the ack timer counts does not reload it
// - packet timer restarts on every stored packet; expiry flushes and interrupts
// - absolute expiry cancels packet timer interrupt; packet timer reloaded and halted (here a packet stored in the expiry cycle restarts it instead)
package rx_moderation_pkg;

	localparam logic [15:0] OFS_Q0_CTRL = 16'h2828;
	localparam logic [15:0] OFS_ABS_DELAY = 16'h282C;
	localparam logic [15:0] OFS_SMALL_SIZE = 16'h2C00;
	localparam logic [15:0] OFS_ACK_DELAY = 16'h2C08;
	localparam logic [15:0] OFS_PKT_DELAY = 16'h2820;
	localparam logic [15:0] OFS_Q1_CTRL = 16'h2928;
	localparam logic [15:0] OFS_STATUS = 16'h2930;
	localparam logic [15:0] OFS_CFG = 16'h2934;

	localparam int PTH_LSB = 0;
	localparam int HTH_LSB = 8;
	localparam int WTH_LSB = 16;
	localparam int UNIT_SEL_BIT = 24;
	localparam int FLUSH_BIT = 31;
	localparam logic [31:0] CTRL_MASK = 32'h013F3F3F;
	localparam logic [31:0] CTRL_RESET = 32'h00010000;
	localparam logic [31:0] SMALL_RESET = 32'h00000000;
	localparam logic [7:0] LINE_WORDS_RESET = 8'h10;

	localparam int DESC_BYTES = 16;
	localparam int TICK_NS = 1024;
	localparam int CLK_NS = 10;
	localparam int TICK_CYCLES = (TICK_NS * 10 + CLK_NS * 10 - 1) / (CLK_NS * 10);
	localparam int VLAN_TAG_BYTES = 4;

endpackage

// >>> design/delay_timer_if.sv
// one moderation countdown timer: controls in, state out
`timescale 1ns/1ps
interface delay_timer_if;
	logic [15:0] load_value;
	logic load;
	logic halt_load;
	logic tick;
	logic running;
	logic expired;
	modport owner (output load_value, output load, output halt_load, output tick, input running, input expired);
	modport timer (input load_value, input load, input halt_load, input tick, output running, output expired);
endinterface

// >>> design/delay_timer.sv
// 16-bit countdown in tick units; a load starts it, a halt-load parks it
`timescale 1ns/1ps
module delay_timer (
	input wire logic clk_i, // core clock
	input wire logic rst_i, // synchronous reset
	delay_timer_if.timer tmr // control and state
);
	typedef struct packed {
		logic [15:0] count;
		logic running;
		logic expired;
	} state_s;
	state_s s_r;
	state_s s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.expired = 1'b0;
		if (tmr.halt_load) begin
			s_nxt.count = tmr.load_value;
			s_nxt.running = 1'b0;
		end else if (tmr.load) begin
			// zero delay means expire at once
			if (tmr.load_value == 16'h0000) begin
				s_nxt.expired = 1'b1;
				s_nxt.running = 1'b0;
			end else begin
				s_nxt.count = tmr.load_value;
				s_nxt.running = 1'b1;
			end
		end else if (s_r.running && tmr.tick) begin
			s_nxt.count = s_r.count - 16'h0001;
			if (s_r.count == 16'h0001) begin
				s_nxt.running = 1'b0;
				s_nxt.expired = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tmr.running = s_r.running;
	assign tmr.expired = s_r.expired;
endmodule

// >>> verif/rx_moderation_props.sv
// port-level assertions for the receive moderation block
`timescale 1ns/1ps
module rx_moderation_props #(
	parameter int TICK_DIV = rx_moderation_pkg::TICK_CYCLES
) (
	input wire logic clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic wb_cyc_i, // cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write
	input wire logic [15:0] wb_adr_i, // address
	input wire logic [3:0] wb_sel_i, // lanes
	input wire logic [31:0] wb_dat_i, // data
	input wire logic wb_ack_o, // ack
	input wire logic [6:0] onchip_valid_i, // on chip
	input wire logic [15:0] host_valid_i, // in host
	input wire logic [6:0] wb_ready_i, // ready
	input wire logic pkt_stored_i, // packet
	input wire logic [13:0] pkt_len_i, // length
	input wire logic vlan_stripped_i, // stripped
	input wire logic ack_rx_i, // ack frame
	input wire logic small_en_i, // small on
	input wire logic ack_en_i, // ack on
	input wire logic prefetch_req_o, // fetch
	input wire logic writeback_req_o, // write back
	input wire logic flush_o, // flush
	input wire logic rx_timer_irq_o, // timer irq
	input wire logic small_irq_o, // small irq
	input wire logic ack_irq_o // ack irq
);
	logic [31:0] ctl_r;
	logic [11:0] size_r;
	logic [15:0] ackd_r;
	logic wr_w;
	// shadows follow full-word writes only; partial writes would leave them stale
	assign wr_w = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i == 4'hF;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl_r <= 32'h00010000;
			size_r <= 12'h000;
			ackd_r <= 16'h0000;
		end else begin
			if (wr_w && wb_adr_i == 16'h2828) ctl_r <= wb_dat_i & 32'h013F3F3F;
			if (wr_w && wb_adr_i == 16'h2C00) size_r <= wb_dat_i[11:0];
			if (wr_w && wb_adr_i == 16'h2C08) ackd_r <= wb_dat_i[15:0];
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_next:
	assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not acked");
	a_ack_pulse:
	assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_prefetch_level:
	assert property ((ctl_r[24] && !$past(rst_i) && !$past(wb_cyc_i) && !$past(wb_cyc_i, 2)) |-> prefetch_req_o ==
		($past(onchip_valid_i) < $past(ctl_r[5:0]) && $past(host_valid_i) >= $past(ctl_r[13:8])))
		else $error("prefetch level wrong");
	a_writeback_due:
	assert property ((ctl_r[24] && !$past(rst_i) && !$past(wb_cyc_i) && !$past(wb_cyc_i, 2) &&
		$past(wb_ready_i) != 7'h00 && $past(wb_ready_i) >= $past(ctl_r[21:16])) |-> writeback_req_o)
		else $error("write back not requested");
	a_flush_with_irq:
	assert property (flush_o == rx_timer_irq_o) else $error("flush and timer irq apart");
	a_timer_irq_pulse:
	assert property (rx_timer_irq_o |=> !rx_timer_irq_o) else $error("timer irq held");
	a_small_irq_due:
	assert property ((pkt_stored_i && small_en_i &&
		pkt_len_i - (vlan_stripped_i ? 14'h0004 : 14'h0000) <= {2'h0, size_r}) |-> ##[1:2] small_irq_o)
		else $error("small packet irq missing");
	a_ack_zero_delay:
	assert property ((ack_rx_i && ack_en_i && ackd_r == 16'h0000 && !$past(ack_rx_i)) |-> ##[1:3] ack_irq_o)
		else $error("ack irq missing");
endmodule
bind rx_moderation rx_moderation_props #(.TICK_DIV(TICK_DIV)) i_rx_moderation_props (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .onchip_valid_i(onchip_valid_i), .host_valid_i(host_valid_i),
	.wb_ready_i(wb_ready_i), .pkt_stored_i(pkt_stored_i), .pkt_len_i(pkt_len_i), .vlan_stripped_i(vlan_stripped_i),
	.ack_rx_i(ack_rx_i), .small_en_i(small_en_i), .ack_en_i(ack_en_i), .prefetch_req_o(prefetch_req_o),
	.writeback_req_o(writeback_req_o), .flush_o(flush_o), .rx_timer_irq_o(rx_timer_irq_o),
	.small_irq_o(small_irq_o), .ack_irq_o(ack_irq_o));

// >>> verif/host_ring_model.sv
// behavioural host ring: descriptors posted by the driver, drained by device fetches
`timescale 1ns/1ps
module host_ring_model (
	input wire logic clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic post_i, // driver sets the level
	input wire logic [15:0] count_i, // new level
	input wire logic stall_i, // slow host, no fetch
	input wire logic fetch_i, // device fetch request
	output logic [15:0] host_valid_o // descriptors in host
);
	// one descriptor a cycle, so the device sees the level fall step by step
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			host_valid_o <= 16'h0000;
		end else if (post_i) begin
			host_valid_o <= count_i;
		end else if (fetch_i && !stall_i && host_valid_o != 16'h0000) begin
			host_valid_o <= host_valid_o - 16'h0001;
		end
	end
endmodule

// >>> verif/tb_top.sv
// self-checking bench for the receive moderation block
`timescale 1ns/1ps
module tb_top;
	logic clk_i, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, pkt = 1'b0, vlan = 1'b0, ack_rx = 1'b0;
	logic small_en = 1'b0, ack_en = 1'b0, post = 1'b0, stall = 1'b1, ack, pf, wbr, fl, tirq, sirq, airq;
	logic [15:0] adr = 16'h0000, cnt = 16'h0000, host_v;
	logic [31:0] dat_w = 32'h00000000, dat_r;
	logic [6:0] onchip = 7'h00, ready = 7'h00;
	logic [13:0] len = 14'h0000;
	int n_mismatch = 0, checks = 0, n_t = 0, n_s = 0, n_a = 0, n_f = 0;
	rx_moderation #(.TICK_DIV(2)) i_rx_moderation (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
		.onchip_valid_i(onchip), .host_valid_i(host_v), .wb_ready_i(ready), .pkt_stored_i(pkt), .pkt_len_i(len),
		.vlan_stripped_i(vlan), .ack_rx_i(ack_rx), .small_en_i(small_en), .ack_en_i(ack_en),
		.prefetch_req_o(pf), .writeback_req_o(wbr), .flush_o(fl), .rx_timer_irq_o(tirq), .small_irq_o(sirq),
		.ack_irq_o(airq));
	host_ring_model i_host_ring_model (.clk_i(clk_i), .rst_i(rst_i), .post_i(post), .count_i(cnt),
		.stall_i(stall), .fetch_i(pf), .host_valid_o(host_v));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// pulse counters move on the falling edge so the clocked tasks read settled values
	always @(negedge clk_i) begin
		if (tirq === 1'b1) n_t++;
		if (sirq === 1'b1) n_s++;
		if (airq === 1'b1) n_a++;
		if (fl === 1'b1) n_f++;
	end
	////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		r = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		cmp(n < 20, 1'b1);
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] exp);
		logic [31:0] r;
		xfer(1'b0, a, 32'h00000000, r);
		cmp(r, exp);
	endtask
	task automatic lvl(input logic [6:0] oc, input logic [15:0] hv, input logic [6:0] rdy, input logic epf,
		input logic ewb);
		@(posedge clk_i);
		onchip <= oc;
		cnt <= hv;
		post <= 1'b1;
		ready <= rdy;
		@(posedge clk_i);
		post <= 1'b0;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		cmp(pf, epf);
		cmp(wbr, ewb);
	endtask
	// kind 0: packet and absolute delays; kind 1: ack delay and ack enable
	task automatic ev(input logic kind, input logic [15:0] d0, input logic [15:0] d1, input int n, input int gap,
		input int lo, input int hi, input int cn);
		int c0, first;
		if (kind == 1'b0) begin
			wr(16'h2820, {16'h0000, d0});
			wr(16'h282C, {16'h0000, d1});
		end else begin
			wr(16'h2C08, {16'h0000, d0});
			ack_en <= d1[0];
		end
		c0 = kind ? n_a : n_t;
		first = -1;
		for (int i = 0; i < 200; i++) begin
			@(posedge clk_i);
			pkt <= !kind && i % gap == 0 && i < n * gap;
			ack_rx <= kind && i % gap == 0 && i < n * gap;
			if (first < 0 && (kind ? n_a : n_t) != c0) first = i;
		end
		cmp((kind ? n_a : n_t) - c0, cn);
		if (cn > 0) cmp(first >= lo && first <= hi, 1'b1);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rd(16'h2828, 32'h00010000);
		rd(16'h282C, 32'h00000000);
		rd(16'h2C08, 32'h00000000);
		rd(16'h2934, 32'h00000010);
		rd(16'h2930, 32'h00000000);
		wr(16'h1000, 32'hFFFFFFFF);
		rd(16'h1000, 32'h00000000);
		wr(16'h2828, 32'hFFFFFFEF);
		rd(16'h2928, 32'h013F3F2F);
		wr(16'h2928, 32'h01000102);
		rd(16'h2828, 32'h013F3F2F);
		rd(16'h2928, 32'h01000102);
	endtask
	task automatic t_levels;
		int n;
		wr(16'h2828, 32'h01050408);
		lvl(7'h07, 16'h0004, 7'h04, 1'b1, 1'b0);
		lvl(7'h08, 16'h0004, 7'h05, 1'b0, 1'b1);
		lvl(7'h07, 16'h0003, 7'h00, 1'b0, 1'b0);
		wr(16'h2828, 32'h00010101);
		lvl(7'h03, 16'h0004, 7'h03, 1'b1, 1'b0);
		lvl(7'h04, 16'h0003, 7'h04, 1'b0, 1'b1);
		lvl(7'h03, 16'h000A, 7'h00, 1'b1, 1'b0);
		@(posedge clk_i);
		stall <= 1'b0;
		n = 0;
		while (pf !== 1'b0 && n < 40) begin
			@(negedge clk_i);
			n++;
		end
		cmp(host_v, 16'h0002);
		cmp(pf, 1'b0);
		@(posedge clk_i);
		stall <= 1'b1;
		// a line of 32 words holds 8 descriptors
		wr(16'h2934, 32'h00000020);
		lvl(7'h07, 16'h0008, 7'h07, 1'b1, 1'b0);
		lvl(7'h08, 16'h0008, 7'h08, 1'b0, 1'b1);
		wr(16'h2934, 32'h00000010);
	endtask
	task automatic t_flush;
		int c0;
		c0 = n_f;
		wr(16'h2820, 32'h80000000);
		repeat (4) @(posedge clk_i);
		cmp(n_f - c0, 1);
		rd(16'h2820, 32'h00000000);
	endtask
	task automatic t_timers;
		ev(1'b0, 16'h000A, 16'h0000, 1, 8, 19, 25, 1);
		ev(1'b0, 16'h000A, 16'h0000, 3, 12, 43, 49, 1);
		ev(1'b0, 16'h0032, 16'h000A, 3, 8, 19, 25, 1);
		ev(1'b0, 16'h000A, 16'h0032, 1, 8, 19, 25, 1);
		ev(1'b0, 16'h0000, 16'h0000, 3, 10, 1, 5, 3);
		ev(1'b0, 16'h0032, 16'h0000, 20, 8, 0, 0, 0);
		ev(1'b1, 16'h000A, 16'h0001, 2, 10, 19, 25, 1);
		ev(1'b1, 16'h0000, 16'h0001, 2, 10, 1, 5, 2);
		ev(1'b1, 16'h0000, 16'h0000, 2, 10, 0, 0, 0);
	endtask
	task automatic t_small;
		logic [13:0] ln [5] = '{14'h0040, 14'h0041, 14'h0044, 14'h0045, 14'h003C};
		logic [4:0] st = 5'h0C, en = 5'h0F, ex = 5'h05;
		int c0;
		wr(16'h2820, 32'h00000000);
		wr(16'h2C00, 32'h00000040);
		for (int i = 0; i < 5; i++) begin
			c0 = n_s;
			@(posedge clk_i);
			len <= ln[i];
			vlan <= st[i];
			small_en <= en[i];
			pkt <= 1'b1;
			@(posedge clk_i);
			pkt <= 1'b0;
			repeat (4) @(posedge clk_i);
			cmp(n_s - c0, ex[i]);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_levels();
		t_flush();
		t_timers();
		t_small();
		stop_test();
	end
	initial begin
		repeat (10000) @(posedge clk_i);
		n_mismatch++;
		stop_test();
	end
endmodule
